//--- bench/qwc_master.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// bus master model: scl stands high between frames
// ----------------------------------------
module qwc_master (
   input wire logic clock,
   output logic scl,
   output logic sda_drv,
   input wire logic sda_line
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // low phase longer than high: the slave answers through its input sampling
   task automatic bit_io(input logic b, output logic r);
      scl = 1'b0;
      repeat (2) @(negedge clock);
      sda_drv = b;
      repeat (3) @(negedge clock);
      scl = 1'b1;
      repeat (3) @(negedge clock);
      r = sda_line;
   endtask : bit_io
   task automatic start;
      sda_drv = 1'b0;
      repeat (4) @(negedge clock);
   endtask : start
   // the scl rise before the data rise also counts as a step in stepping mode
   task automatic stop;
      scl = 1'b0;
      repeat (2) @(negedge clock);
      sda_drv = 1'b0;
      repeat (3) @(negedge clock);
      scl = 1'b1;
      repeat (4) @(negedge clock);
      sda_drv = 1'b1;
      repeat (8) @(negedge clock);
   endtask : stop
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = (r === 1'b0);
   endtask : wr_byte
   task automatic rd_byte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(!mack, r);
   endtask : rd_byte
endmodule : qwc_master
`default_nettype wire

//--- bench/test_quad_wiper_command_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module test_quad_wiper_command_decoder;
   localparam int nvc = 200;
   localparam logic [7:0] adr = 8'ha5;
   typedef struct packed {
      logic [7:0] ins;
      logic [7:0] dat;
      logic [1:0] kind;
      logic [31:0] pos;
   } qwc_row_type;
   logic clock, rst, scl, sda_drv, sda_out, sda_oe_n, write_guard_n, nv_busy, a;
   logic [3:0] pin_address_bits;
   logic [31:0] wiper_pos;
   logic [1023:0] tap_sel;
   logic [2:0] acks;
   logic [7:0] rd;
   wire logic sda_line;
   int fail_count = 0, num_checks = 0, busy_len = 0, cyc = 0;
   // kind: 0 write, 1 read (dat is the expected byte), 2 copy
   qwc_row_type rows [11] = '{
      '{8'ha0, 8'h11, 2'h0, 32'h80808011}, '{8'ha3, 8'h22, 2'h0, 32'h22808011},
      '{8'h90, 8'h11, 2'h1, 32'h22808011}, '{8'hc9, 8'h33, 2'h0, 32'h22808011},
      '{8'hb9, 8'h33, 2'h1, 32'h22808011}, '{8'hd9, 8'h00, 2'h2, 32'h22803311},
      '{8'he8, 8'h00, 2'h2, 32'h22803311}, '{8'h18, 8'h00, 2'h2, 32'h80803311},
      '{8'h84, 8'h00, 2'h2, 32'h80803311}, '{8'ha2, 8'h44, 2'h0, 32'h80443311},
      '{8'h14, 8'h00, 2'h2, 32'h80803311}};
   // released line floats up through the pull-up
   assign sda_line = sda_drv & (sda_oe_n | sda_out);
   qwc_decoder #(.NV_WRITE_CYCLES(nvc)) DUT (.clock(clock), .rst(rst), .scl(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .pin_address_bits(pin_address_bits), .write_guard_n(write_guard_n),
      .wiper_pos(wiper_pos), .tap_sel(tap_sel), .nv_busy(nv_busy));
   qwc_master master (.clock(clock), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
   // ----------------------------------------
   // checking helpers
   // ----------------------------------------
   task automatic wrap_up;
      if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_tap(input logic [1023:0] got, input logic [1023:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_tap
   function automatic logic [1023:0] taps(input logic [31:0] pos);
      logic [1023:0] t;
      t = '0;
      for (int p = 0; p < 4; p++) t[256 * p + int'(pos[8 * p +: 8])] = 1'b1;
      return t;
   endfunction : taps
   task automatic cmd(input logic [7:0] ad, input logic [7:0] ins, input logic [7:0] dat,
      input logic [1:0] kind);
      master.start();
      master.wr_byte(ad, acks[2]);
      master.wr_byte(ins, acks[1]);
      acks[0] = 1'b0;
      if (kind == 2'h0) master.wr_byte(dat, acks[0]);
      else if (kind == 2'h1) master.rd_byte(1'b0, rd);
      master.stop();
   endtask : cmd
   // bounded wait: a stuck busy flag must not hang the run
   task automatic wait_idle;
      for (int i = 0; i < 4 * nvc && nv_busy !== 1'b0; i++) @(negedge clock);
   endtask : wait_idle
   // ----------------------------------------
   // clock, cycle ceiling, busy length
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (nv_busy === 1'b1) busy_len++;
      if (cyc == 30000) begin
         fail_count++;
         wrap_up();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      write_guard_n = 1'b1;
      pin_address_bits = 4'h5;
      repeat (12) @(negedge clock);
      rst = 1'b0;
      repeat (8) @(negedge clock);
      chk_val(wiper_pos, 32'h80808080);
      chk_bit(nv_busy, 1'b0);
      chk_bit(sda_oe_n, 1'b1);
      foreach (rows[i]) begin
         cmd(adr, rows[i].ins, rows[i].dat, rows[i].kind);
         chk_val({29'h0, acks}, {29'h0, 2'h3, rows[i].kind == 2'h0});
         if (rows[i].kind == 2'h1) chk_val({24'h0, rd}, {24'h0, rows[i].dat});
         wait_idle();
         chk_val(wiper_pos, rows[i].pos);
         chk_tap(tap_sel, taps(rows[i].pos));
      end
      chk_bit(&acks[2:1], 1'b1);
      cmd(adr, 8'hb5, 8'h00, 2'h1);
      chk_val({24'h0, rd}, 32'h00000033);
      busy_len = 0;
      cmd(adr, 8'hc6, 8'h5a, 2'h0);
      master.start();
      master.wr_byte(adr, a);
      master.stop();
      chk_bit(a, 1'b0);
      wait_idle();
      chk_val(busy_len, nvc);
      cmd(adr, 8'hb6, 8'h00, 2'h1);
      chk_val({24'h0, rd}, 32'h0000005a);
      write_guard_n = 1'b0;
      cmd(adr, 8'hc6, 8'ha5, 2'h0);
      chk_bit(acks[0], 1'b0);
      chk_bit(nv_busy, 1'b0);
      write_guard_n = 1'b1;
      cmd(adr, 8'hb6, 8'h00, 2'h1);
      chk_val({24'h0, rd}, 32'h0000005a);
      cmd(8'h35, 8'ha0, 8'hee, 2'h0);
      chk_bit(acks[2], 1'b0);
      cmd(8'ha6, 8'ha0, 8'hee, 2'h0);
      chk_bit(acks[2], 1'b0);
      chk_val(wiper_pos, 32'h80803311);
      master.start();
      master.wr_byte(adr, a);
      master.wr_byte(8'h21, a);
      chk_bit(a, 1'b1);
      for (int i = 0; i < 4; i++) master.bit_io(i < 3, a);
      master.stop();
      chk_val(wiper_pos, 32'h80803411);
      // pulses with no start must not move the wiper
      for (int i = 0; i < 3; i++) master.bit_io(1'b1, a);
      repeat (8) @(negedge clock);
      chk_val(wiper_pos, 32'h80803411);
      wrap_up();
   end
endmodule : test_quad_wiper_command_decoder
`default_nettype wire

//--- src/qwc_decoder.sv
`timescale 1ns/1ns
`default_nettype none
`include "qwc_map.svh"
module qwc_decoder #(
   parameter logic [3:0] DEV_TYPE = 4'ha, // arbitrary value
   parameter int NV_WRITE_CYCLES = `QWC_NV_WRITE_US * `QWC_CLK_MHZ,
   parameter logic [7:0] NV_INIT = 8'h80
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic [3:0] pin_address_bits,
   input wire logic write_guard_n,
   output logic [31:0] wiper_pos,
   output logic [1023:0] tap_sel,
   output logic nv_busy
);
   localparam int CW = $clog2(NV_WRITE_CYCLES + 1);
   // ---------------------------------------------------------------
   // input sampling
   // ---------------------------------------------------------------
   logic [6:0] s1_q, s2_q, s3_q, filt_q;
   logic [1:0] prev_q;
   logic scl_q, sda_q, scl_rise, scl_fall, start_ev, stop_ev, guard_ok;
   logic [3:0] pins;
   always_ff @(posedge clock) begin
      if (rst) begin
         s1_q <= `QWC_IN_RESET;
         s2_q <= `QWC_IN_RESET;
         s3_q <= `QWC_IN_RESET;
         filt_q <= `QWC_IN_RESET;
         prev_q <= 2'h3;
      end else begin
         s1_q <= {write_guard_n, pin_address_bits, sda_in, scl};
         s2_q <= s1_q;
         s3_q <= s2_q;
         // a change counts only once two stages agree: glitch filter
         filt_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
         prev_q <= filt_q[1:0];
      end
   end
   assign scl_q = filt_q[0];
   assign sda_q = filt_q[1];
   assign pins = filt_q[5:2];
   assign guard_ok = filt_q[6];
   assign scl_rise = scl_q & ~prev_q[0];
   assign scl_fall = ~scl_q & prev_q[0];
   assign start_ev = scl_q & prev_q[0] & prev_q[1] & ~sda_q;
   assign stop_ev = scl_q & prev_q[0] & ~prev_q[1] & sda_q;
   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic legal_instr(input logic [7:0] b);
      logic ok;
      ok = 1'b0;
      unique case (b[7:4]) // R3
         `QWC_OP_RD_WIPER, `QWC_OP_WR_WIPER, `QWC_OP_STEP: ok = (b[3:2] == 2'h0);
         `QWC_OP_RD_NV, `QWC_OP_WR_NV: ok = 1'b1;
         `QWC_OP_NV_TO_WIPER, `QWC_OP_WIPER_TO_NV: ok = 1'b1;
         `QWC_OP_GANG_TO_WIPER, `QWC_OP_GANG_TO_NV: ok = (b[1:0] == 2'h0);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : legal_instr
   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   qwc_pkg::qwc_state_type state_q;
   qwc_pkg::qwc_pend_type pend_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q, instr_q, pend_data_q;
   logic drive_q, mack_q, boot_q, ack_w, ack_fall, lead_q;
   logic [7:0] wiper_q [4];
   logic [7:0] stored_q [16];
   logic [CW-1:0] busy_cnt_q;
   logic [1:0] pot, slot;
   logic [3:0] nv_idx;
   logic [7:0] rd_val, sel_wiper;
   assign pot = instr_q[1:0];
   assign slot = instr_q[3:2];
   assign nv_idx = {pot, slot}; // R4
   assign sel_wiper = wiper_q[pot];
   assign rd_val = (instr_q[7:4] == `QWC_OP_RD_NV) ? stored_q[nv_idx] : sel_wiper; // R9 R11
   assign nv_busy = (busy_cnt_q != '0);
   assign ack_fall = scl_fall & (bit_cnt_q == `QWC_ACK_BIT) & drive_q;
   always_comb begin
      ack_w = 1'b0;
      if (state_q == qwc_pkg::st_addr) begin
         // R1 R2 R23
         ack_w = (shift_q[7:4] == DEV_TYPE) && (shift_q[3:0] == pins) && !nv_busy;
      end else if (state_q == qwc_pkg::st_instr) begin
         ack_w = legal_instr(shift_q);
      end else if (state_q == qwc_pkg::st_rx) begin
         ack_w = !((instr_q[7:4] == `QWC_OP_WR_NV) && !guard_ok); // R24
      end
   end
   // ---------------------------------------------------------------
   // bus engine
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= qwc_pkg::st_idle;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         instr_q <= 8'h00;
         drive_q <= 1'b0;
         mack_q <= 1'b0;
         lead_q <= 1'b0;
      end else if (start_ev) begin
         state_q <= qwc_pkg::st_addr;
         bit_cnt_q <= 4'h0;
         drive_q <= 1'b0;
         lead_q <= 1'b1;
      end else if (stop_ev) begin
         state_q <= qwc_pkg::st_idle; // R25
         drive_q <= 1'b0;
         lead_q <= 1'b0;
      end else if (scl_rise) begin
         if (bit_cnt_q != `QWC_ACK_BIT && state_q != qwc_pkg::st_tx) begin
            shift_q <= {shift_q[6:0], sda_q};
         end
         if (bit_cnt_q == `QWC_ACK_BIT && state_q == qwc_pkg::st_tx) begin
            mack_q <= !sda_q;
         end
      end else if (scl_fall && lead_q) begin
         // the fall after a start opens bit one and ends none; counting it acks a bit early
         lead_q <= 1'b0;
      end else if (scl_fall && (state_q == qwc_pkg::st_addr || state_q == qwc_pkg::st_instr
            || state_q == qwc_pkg::st_rx || state_q == qwc_pkg::st_tx)) begin
         if (bit_cnt_q < `QWC_LAST_BIT) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (state_q == qwc_pkg::st_tx) begin
               drive_q <= !shift_q[3'(4'h6 - bit_cnt_q)];
            end
         end else if (bit_cnt_q == `QWC_LAST_BIT) begin
            bit_cnt_q <= `QWC_ACK_BIT;
            drive_q <= ack_w; // R18
            if (state_q == qwc_pkg::st_instr) begin
               instr_q <= shift_q;
            end
         end else begin
            bit_cnt_q <= 4'h0;
            drive_q <= 1'b0;
            unique case (state_q)
               qwc_pkg::st_addr: state_q <= drive_q ? qwc_pkg::st_instr : qwc_pkg::st_hold;
               qwc_pkg::st_instr: begin
                  if (!drive_q) begin
                     state_q <= qwc_pkg::st_hold;
                  end else if (instr_q[7:4] == `QWC_OP_RD_WIPER
                        || instr_q[7:4] == `QWC_OP_RD_NV) begin
                     state_q <= qwc_pkg::st_tx;
                     shift_q <= rd_val;
                     drive_q <= !rd_val[7];
                  end else if (instr_q[7:4] == `QWC_OP_WR_WIPER
                        || instr_q[7:4] == `QWC_OP_WR_NV) begin
                     state_q <= qwc_pkg::st_rx; // R18
                  end else if (instr_q[7:4] == `QWC_OP_STEP) begin
                     state_q <= qwc_pkg::st_step; // R17
                  end else begin
                     state_q <= qwc_pkg::st_hold; // R19
                  end
               end
               qwc_pkg::st_rx: state_q <= qwc_pkg::st_hold;
               qwc_pkg::st_tx: begin
                  // master ack: send the same byte again; nack: wait for stop
                  state_q <= mack_q ? qwc_pkg::st_tx : qwc_pkg::st_hold;
                  drive_q <= mack_q & !shift_q[7];
               end
               default: state_q <= qwc_pkg::st_hold;
            endcase
         end
      end
   end
   // ---------------------------------------------------------------
   // pending operation, run at stop
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst || start_ev || stop_ev) begin
         pend_q <= qwc_pkg::pend_none;
         if (rst) begin
            pend_data_q <= 8'h00;
         end
      end else if (ack_fall && state_q == qwc_pkg::st_rx
            && instr_q[7:4] == `QWC_OP_WR_NV) begin
         pend_q <= qwc_pkg::pend_nv_wr; // R12
         pend_data_q <= shift_q;
      end else if (ack_fall && state_q == qwc_pkg::st_instr) begin
         unique case (instr_q[7:4])
            `QWC_OP_NV_TO_WIPER: pend_q <= qwc_pkg::pend_to_wiper; // R13
            `QWC_OP_WIPER_TO_NV: pend_q <= qwc_pkg::pend_to_nv; // R14
            `QWC_OP_GANG_TO_WIPER: pend_q <= qwc_pkg::pend_gang_to_wiper; // R15
            `QWC_OP_GANG_TO_NV: pend_q <= qwc_pkg::pend_gang_to_nv; // R16
            default: pend_q <= qwc_pkg::pend_none;
         endcase
      end
   end
   logic nv_commit;
   assign nv_commit = stop_ev && guard_ok && (pend_q == qwc_pkg::pend_nv_wr
      || pend_q == qwc_pkg::pend_to_nv || pend_q == qwc_pkg::pend_gang_to_nv);
   // ---------------------------------------------------------------
   // wipers
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         boot_q <= 1'b1;
         for (int p = 0; p < 4; p++) begin
            wiper_q[p] <= 8'h00;
         end
      end else begin
         boot_q <= 1'b0;
         if (boot_q) begin
            for (int p = 0; p < 4; p++) begin
               wiper_q[p] <= stored_q[{2'(p), `QWC_BOOT_SLOT}]; // R6
            end
         end else if (ack_fall && state_q == qwc_pkg::st_rx
               && instr_q[7:4] == `QWC_OP_WR_WIPER) begin
            wiper_q[pot] <= shift_q; // R10
         end else if (scl_rise && state_q == qwc_pkg::st_step && !stop_ev) begin
            if (sda_q && sel_wiper != 8'hff) begin
               wiper_q[pot] <= sel_wiper + 8'h01; // R21
            end else if (!sda_q && sel_wiper != 8'h00) begin
               wiper_q[pot] <= sel_wiper - 8'h01; // R22
            end
         end else if (stop_ev && pend_q == qwc_pkg::pend_to_wiper) begin
            wiper_q[pot] <= stored_q[nv_idx]; // R13
         end else if (stop_ev && pend_q == qwc_pkg::pend_gang_to_wiper) begin
            for (int p = 0; p < 4; p++) begin
               wiper_q[p] <= stored_q[{2'(p), slot}]; // R15
            end
         end
      end
   end
   // ---------------------------------------------------------------
   // stored settings
   // ---------------------------------------------------------------
   // reset stands in for factory content; real cells would keep it
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) begin
            stored_q[i] <= NV_INIT; // R7
         end
      end else if (nv_commit) begin // R24
         unique case (pend_q)
            qwc_pkg::pend_nv_wr: stored_q[nv_idx] <= pend_data_q; // R12
            qwc_pkg::pend_to_nv: stored_q[nv_idx] <= sel_wiper; // R14
            default: begin
               for (int p = 0; p < 4; p++) begin
                  stored_q[{2'(p), slot}] <= wiper_q[p]; // R16
               end
            end
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         busy_cnt_q <= '0;
      end else if (nv_commit) begin
         busy_cnt_q <= CW'(NV_WRITE_CYCLES); // R8 R20
      end else if (nv_busy) begin
         busy_cnt_q <= busy_cnt_q - CW'(1);
      end
   end
   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign sda_out = 1'b0;
   assign sda_oe_n = !drive_q;
   for (genvar p = 0; p < 4; p++) begin : g_tap
      assign wiper_pos[p*8 +: 8] = wiper_q[p];
      assign tap_sel[p*256 +: 256] = 256'(1) << wiper_q[p]; // R5
   end
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   logic addr_last;
   assign addr_last = scl_fall && state_q == qwc_pkg::st_addr && bit_cnt_q == `QWC_LAST_BIT;
   property p_type;
      @(posedge clock) disable iff (rst)
      addr_last && shift_q[7:4] != DEV_TYPE && !start_ev && !stop_ev |=> !drive_q;
   endproperty
   a_type: assert property (p_type) else $error("wrong type acked"); // R1
   property p_pins;
      @(posedge clock) disable iff (rst)
      addr_last && shift_q[3:0] != pins && !start_ev && !stop_ev |=> !drive_q;
   endproperty
   a_pins: assert property (p_pins) else $error("wrong address acked"); // R2
   property p_busy;
      @(posedge clock) disable iff (rst)
      addr_last && nv_busy && !start_ev && !stop_ev |=> !drive_q;
   endproperty
   a_busy: assert property (p_busy) else $error("acked while busy"); // R23
   property p_guard;
      @(posedge clock) disable iff (rst)
      (stop_ev && !guard_ok) |=> stored_q[nv_idx] == $past(stored_q[nv_idx]);
   endproperty
   a_guard: assert property (p_guard) else $error("guarded slot changed"); // R24
   property p_up;
      @(posedge clock) disable iff (rst)
      scl_rise && state_q == qwc_pkg::st_step && sda_q && !stop_ev && !start_ev
         && sel_wiper != 8'hff |=> sel_wiper == $past(sel_wiper) + 8'h01;
   endproperty
   a_up: assert property (p_up) else $error("step up missed"); // R21
   property p_dn;
      @(posedge clock) disable iff (rst)
      scl_rise && state_q == qwc_pkg::st_step && !sda_q && !stop_ev && !start_ev
         && sel_wiper != 8'h00 |=> sel_wiper == $past(sel_wiper) - 8'h01;
   endproperty
   a_dn: assert property (p_dn) else $error("step down missed"); // R22
   property p_stop;
      @(posedge clock) disable iff (rst)
      stop_ev |=> state_q == qwc_pkg::st_idle && !drive_q ##1 state_q != qwc_pkg::st_step;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not honoured"); // R25
   property p_prog;
      @(posedge clock) disable iff (rst)
      nv_commit |=> nv_busy && busy_cnt_q == CW'(NV_WRITE_CYCLES);
   endproperty
   a_prog: assert property (p_prog) else $error("program time wrong"); // R20
   property p_boot;
      @(posedge clock) disable iff (rst)
      boot_q |=> wiper_q[0] == $past(stored_q[0]) && wiper_q[3] == $past(stored_q[12]);
   endproperty
   a_boot: assert property (p_boot) else $error("boot load wrong"); // R6
endmodule : qwc_decoder
`default_nettype wire

//--- src/qwc_map.svh
`ifndef QWC_MAP_SVH
`define QWC_MAP_SVH
// Notes on behaviour
// R1: address byte comes first; its top four bits must equal the device type.
// R2: low four address bits must equal the pin address bits, else ignore.
// R3: instruction byte: opcode in 7:4, slot select in 3:2, pot select in 1:0.
// R4: slot select values 0 to 3 pick stored slots zero to three.
// R5: four 8-bit wiper registers, each decoded to one of 256 taps.
// R6: after power-up each wiper loads from its stored slot zero.
// R7: four 8-bit stored-setting registers per pot, host and wiper reachable.
// R8: any stored-setting change completes within 10 ms.
// R9: opcode 1001, slot 00, returns the selected wiper value.
// R10: opcode 1010, slot 00, writes the data byte into the selected wiper.
// R11: opcode 1011 returns the selected stored-setting value.
// R12: opcode 1100 writes the data byte into the selected stored setting.
// R13: opcode 1101 copies the selected stored slot into its wiper.
// R14: opcode 1110 copies the wiper into the selected slot, starting a program.
// R15: opcode 0001, pot 00, copies the slot into all four wipers.
// R16: opcode 1000, pot 00, copies all four wipers into the slot.
// R17: opcode 0010, slot 00, enters stepping mode for the selected wiper.
// R18: reads and writes use address, instruction, one data byte, each acked.
// R19: copies use address and instruction only, then a stop.
// R20: wiper to stored copy is a non-volatile write of the write-cycle time.
// R21: in stepping, each SCL high with SDA high moves the wiper one tap up.
// R22: in stepping, each SCL high with SDA low moves the wiper one tap down.
// R23: while programming, the address is not acknowledged.
// R24: guard pin low: no ack on data byte, stored settings not programmed.
// R25: a stop ends stepping and every sequence until a new start.
`define QWC_OP_GANG_TO_WIPER 4'h1
`define QWC_OP_STEP 4'h2
`define QWC_OP_GANG_TO_NV 4'h8
`define QWC_OP_RD_WIPER 4'h9
`define QWC_OP_WR_WIPER 4'ha
`define QWC_OP_RD_NV 4'hb
`define QWC_OP_WR_NV 4'hc
`define QWC_OP_NV_TO_WIPER 4'hd
`define QWC_OP_WIPER_TO_NV 4'he
`define QWC_CLK_MHZ 50
`define QWC_NV_WRITE_US 5000
`define QWC_BOOT_SLOT 2'h0
`define QWC_ACK_BIT 4'h8
`define QWC_LAST_BIT 4'h7
`define QWC_IN_RESET 7'h7f
`endif

//--- src/qwc_pkg.sv
package qwc_pkg;
   typedef enum logic [6:0] {
      st_idle = 7'h01,
      st_addr = 7'h02,
      st_instr = 7'h04,
      st_rx = 7'h08,
      st_tx = 7'h10,
      st_step = 7'h20,
      st_hold = 7'h40
   } qwc_state_type;
   typedef enum logic [2:0] {
      pend_none = 3'h0,
      pend_nv_wr = 3'h1,
      pend_to_wiper = 3'h2,
      pend_gang_to_wiper = 3'h3,
      pend_to_nv = 3'h4,
      pend_gang_to_nv = 3'h5
   } qwc_pend_type;
endpackage : qwc_pkg
